// ===== pkg/tss_pkg.sv
package tss_pkg;
   localparam int LANES = 4;
   localparam int BIT_RATE_KBPS = 2048;
   localparam int FRAME_US = 125;
   // Bit clock falling edges per frame, two per bit
   localparam int FRAME_EDGES = 2 * BIT_RATE_KBPS * FRAME_US / 1000;
   localparam int REGION_BIT = 5;
   localparam logic [5:0] SWITCH_CONTROL_OFFSET = 6'h00;
   localparam int CTRL_SPLIT_BIT = 7;
   localparam int CTRL_BCAST_BIT = 6;
   localparam int CTRL_MSEL_LSB = 3;
   localparam int CTRL_STREAM_LSB = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'hdb;
   localparam logic [1:0] MSEL_DATA = 2'h1;
   localparam logic [1:0] MSEL_CML = 2'h2;
   localparam logic [1:0] MSEL_CMH = 2'h3;
   localparam int CMH_OE_BIT = 0;
   localparam int CMH_CTL_BIT = 1;
   localparam int CMH_MSG_BIT = 2;

   typedef enum logic {ACC_IDLE = 1'b0, ACC_DONE = 1'b1} acc_state_type;

   typedef struct packed {
      logic [4:0]      chan;
      logic [3:0][7:0] data;
   } rx_word_type;

   typedef struct packed {
      logic       cs_n;
      logic       strobe;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] din;
   } bus_in_type;

   typedef struct packed {
      logic              bclk_s1, bclk_s2, bclk_d;
      logic              fp_s1, fp_s2, ode_s1, ode_s2;
      logic [3:0]        sin_s1, sin_s2;
      bus_in_type        b1, b2;
      logic [8:0]        cnt;
      logic [3:0][7:0]   rx_sh;
      logic              rx_pend;
      rx_word_type       rx_word;
      rx_word_type [1:0] fifo;
      logic              wp, rp;
      logic [1:0]        fcount;
      logic [127:0][7:0] dmem;
      logic [127:0][7:0] cml;
      logic [127:0][2:0] cmh;
      logic [7:0]        ctrl;
      logic [3:0][7:0]   tx_sh;
      logic [3:0]        tx_oe, tx_ctl;
      acc_state_type     acc;
      logic              ack;
      logic [7:0]        dout;
   } state_type;
endpackage : tss_pkg

// ===== rtl/tdm_time_slot_switch.sv
`timescale 1ns/1ps
`default_nettype none
module tdm_time_slot_switch (
   input  wire logic       mclk,                // System clock 250 MHz
   input  wire logic       rstn,                // Synchronous reset
   input  wire logic       bit_clock_n,         // Inverted 4.096 MHz clock
   input  wire logic       frame_pulse_n,       // Frame pulse
   input  wire logic [3:0] serial_in_lane,      // Serial inputs
   input  wire logic       output_drive_enable, // Global drive enable
   output logic      [3:0] serial_out_lane,     // Serial outputs
   output logic      [3:0] serial_out_oe,       // Output enables
   output logic      [3:0] channel_control_out, // Per-channel control
   input  wire logic       chip_select_n,       // Chip select
   input  wire logic       access_strobe,       // Data strobe
   input  wire logic       read_write,          // High read, low write
   input  wire logic       region_select_line,  // Top address line
   input  wire logic [4:0] bus_addr_low,        // Channel address
   input  wire logic [7:0] bus_data_in,         // Data from processor
   output logic      [7:0] bus_data_out,        // Data to processor
   output logic            bus_data_oe,         // Data bus drive
   output logic            access_ack_n_out,    // Acknowledge level
   output logic            access_ack_n_oe      // Acknowledge pull-down
);
   tss_pkg::state_type st_reg, st_next;

   logic              fall, boundary, load, sample, word_done;
   logic [8:0]        cnt_new;
   logic [4:0]        chan;
   logic [3:0][7:0]   load_byte, load_cml;
   logic [3:0]        load_msg, load_oe, load_ctl;
   logic              full, empty, push, pop, dmem_busy;
   tss_pkg::rx_word_type head;
   logic              bus_act, bus_go, region, split, bus_rd;
   logic [1:0]        msel;
   logic [6:0]        bus_idx;

   // Memory index from stream and channel
   function automatic logic [6:0] idx(input logic [1:0] s,
                                      input logic [4:0] c);
      idx = {s, c};
   endfunction : idx

   // Timing from bit clock edges and frame pulse only
   assign fall = st_reg.bclk_d & ~st_reg.bclk_s2;
   assign cnt_new = !st_reg.fp_s2 ? 9'h000 :
      (st_reg.cnt == 9'(tss_pkg::FRAME_EDGES - 1)) ? 9'h000
      : st_reg.cnt + 9'h001;
   // Even edge count marks a cell boundary, odd samples mid-cell
   assign boundary = fall & ~cnt_new[0];
   assign load = boundary & (cnt_new[3:0] == 4'h0);
   assign sample = fall & cnt_new[0];
   assign word_done = sample & (cnt_new[3:1] == 3'h7);
   assign chan = cnt_new[8:4];

   // Per-lane transmit selection from connection memories
   always_comb begin
      for (int s = 0; s < tss_pkg::LANES; s++) begin
         load_cml[s] = st_reg.cml[idx(2'(s), chan)];
         load_msg[s] = st_reg.ctrl[tss_pkg::CTRL_BCAST_BIT]
            | st_reg.cmh[idx(2'(s), chan)][tss_pkg::CMH_MSG_BIT];
         load_oe[s] = st_reg.ctrl[tss_pkg::CTRL_BCAST_BIT]
            | st_reg.cmh[idx(2'(s), chan)][tss_pkg::CMH_OE_BIT];
         load_ctl[s] = st_reg.cmh[idx(2'(s), chan)][tss_pkg::CMH_CTL_BIT];
         load_byte[s] = load_msg[s] ? load_cml[s]
            : st_reg.dmem[load_cml[s][6:0]];
      end
   end

   // Two-entry receive buffer
   assign full = st_reg.fcount == 2'h2;
   assign empty = st_reg.fcount == 2'h0;
   assign head = st_reg.fifo[st_reg.rp];
   assign push = st_reg.rx_pend & ~full;
   assign pop = ~empty & ~dmem_busy;

   // Processor access decode
   assign bus_act = ~st_reg.b2.cs_n & st_reg.b2.strobe;
   assign bus_go = bus_act & (st_reg.acc == tss_pkg::ACC_IDLE);
   assign region = st_reg.b2.addr[tss_pkg::REGION_BIT];
   assign split = st_reg.ctrl[tss_pkg::CTRL_SPLIT_BIT];
   assign msel = st_reg.ctrl[tss_pkg::CTRL_MSEL_LSB +: 2];
   assign bus_rd = st_reg.b2.rd;
   assign bus_idx = idx(st_reg.ctrl[tss_pkg::CTRL_STREAM_LSB +: 2],
                        st_reg.b2.addr[4:0]);
   // Data memory has one port; a processor data memory read stalls the buffer drain
   assign dmem_busy = bus_go & bus_rd & region
      & (split | (msel == tss_pkg::MSEL_DATA));

   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.bclk_s1 = bit_clock_n;
      st_next.bclk_s2 = st_reg.bclk_s1;
      st_next.bclk_d = st_reg.bclk_s2;
      st_next.fp_s1 = frame_pulse_n;
      st_next.fp_s2 = st_reg.fp_s1;
      st_next.ode_s1 = output_drive_enable;
      st_next.ode_s2 = st_reg.ode_s1;
      st_next.sin_s1 = serial_in_lane;
      st_next.sin_s2 = st_reg.sin_s1;
      st_next.b1 = '{chip_select_n, access_strobe, read_write,
                     {region_select_line, bus_addr_low}, bus_data_in};
      st_next.b2 = st_reg.b1;
      if (fall) begin
         st_next.cnt = cnt_new;
      end
      // Receive shift, mid-cell sampling
      if (sample) begin
         for (int s = 0; s < tss_pkg::LANES; s++) begin
            st_next.rx_sh[s] = {st_reg.rx_sh[s][6:0], st_reg.sin_s2[s]};
         end
      end
      // Push clears pending before a new word may set it again
      if (push) begin
         st_next.fifo[st_reg.wp] = st_reg.rx_word;
         st_next.wp = ~st_reg.wp;
         st_next.rx_pend = 1'b0;
      end
      // A stalled word waits; a later word overwrites the held one
      if (word_done) begin
         st_next.rx_pend = 1'b1;
         st_next.rx_word.chan = chan;
         for (int s = 0; s < tss_pkg::LANES; s++) begin
            st_next.rx_word.data[s] = st_next.rx_sh[s];
         end
      end
      // Drain to data memory, newest byte overwrites
      if (pop) begin
         for (int s = 0; s < tss_pkg::LANES; s++) begin
            st_next.dmem[idx(2'(s), head.chan)] = head.data[s];
         end
         st_next.rp = ~st_reg.rp;
      end
      st_next.fcount = st_reg.fcount + 2'(push) - 2'(pop);
      // Transmit: settings latched per slot so changes wait a slot
      if (load) begin
         st_next.tx_sh = load_byte;
         st_next.tx_oe = load_oe;
         st_next.tx_ctl = load_ctl;
      end else if (boundary) begin
         for (int s = 0; s < tss_pkg::LANES; s++) begin
            st_next.tx_sh[s] = {st_reg.tx_sh[s][6:0], 1'b0};
         end
      end
      // Access handling: one cycle to process, then acknowledge
      unique case (st_reg.acc)
         tss_pkg::ACC_IDLE: begin
            if (bus_act) begin
               st_next.acc = tss_pkg::ACC_DONE;
               st_next.ack = 1'b1;
               st_next.dout = 8'h00;
               if (!region) begin
                  if (bus_rd) begin
                     st_next.dout = st_reg.ctrl;
                  end else begin
                     st_next.ctrl = st_reg.b2.din & tss_pkg::CTRL_WMASK;
                  end
               end else if (bus_rd) begin
                  if (split || msel == tss_pkg::MSEL_DATA) begin
                     st_next.dout = st_reg.dmem[bus_idx];
                  end else if (msel == tss_pkg::MSEL_CML) begin
                     st_next.dout = st_reg.cml[bus_idx];
                  end else if (msel == tss_pkg::MSEL_CMH) begin
                     st_next.dout = {5'h00, st_reg.cmh[bus_idx]};
                  end
               end else if (split || msel == tss_pkg::MSEL_CML) begin
                  st_next.cml[bus_idx] = st_reg.b2.din;
               end else if (msel == tss_pkg::MSEL_CMH) begin
                  st_next.cmh[bus_idx] = st_reg.b2.din[2:0];
               end
            end
         end
         tss_pkg::ACC_DONE: begin
            // Hold acknowledge until the strobe or select drops
            if (!bus_act) begin
               st_next.acc = tss_pkg::ACC_IDLE;
               st_next.ack = 1'b0;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st_reg <= '0;
         st_reg.ctrl <= tss_pkg::CTRL_RESET;
         st_reg.acc <= tss_pkg::ACC_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs
   assign serial_out_lane = {st_reg.tx_sh[3][7], st_reg.tx_sh[2][7],
                             st_reg.tx_sh[1][7], st_reg.tx_sh[0][7]};
   assign serial_out_oe = st_reg.ode_s2 ? st_reg.tx_oe : 4'h0;
   assign channel_control_out = st_reg.tx_ctl;
   assign bus_data_out = st_reg.dout;
   assign bus_data_oe = (st_reg.acc == tss_pkg::ACC_DONE) & bus_rd & bus_act;
   assign access_ack_n_out = 1'b0;
   assign access_ack_n_oe = st_reg.ack;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_ode_off;
      !st_reg.ode_s2 |-> serial_out_oe == 4'h0;
   endproperty
   a_ode_off: assert property (p_ode_off)
      else $error("outputs driven with drive enable low");

   // Drive enable may drop in the very next cycle and then wins
   property p_bcast_drive;
      load && st_reg.ctrl[tss_pkg::CTRL_BCAST_BIT] && st_reg.ode_s2
         |=> serial_out_oe == 4'hf || !st_reg.ode_s2;
   endproperty
   a_bcast_drive: assert property (p_bcast_drive)
      else $error("broadcast slot not driven on every lane");

   property p_frame_reset;
      fall && !st_reg.fp_s2 |=> st_reg.cnt == 9'h000;
   endproperty
   a_frame_reset: assert property (p_frame_reset)
      else $error("frame pulse did not reset the counter");

   property p_cell_shift;
      boundary && !load |=> st_reg.tx_sh[0] == ($past(st_reg.tx_sh[0]) << 1);
   endproperty
   a_cell_shift: assert property (p_cell_shift)
      else $error("transmit did not shift at cell boundary");

   // Lane 0 switched slot: byte read straight from the addressed location
   property p_slot_load;
      load && !load_msg[0] |=>
         st_reg.tx_sh[0] == $past(st_reg.dmem[st_reg.cml[chan][6:0]]);
   endproperty
   a_slot_load: assert property (p_slot_load)
      else $error("wrong byte loaded for slot");

   property p_msg_load;
      load && load_msg[0] |=> st_reg.tx_sh[0] == $past(load_cml[0]);
   endproperty
   a_msg_load: assert property (p_msg_load)
      else $error("message slot did not send low entry");

   property p_ctrl_write;
      bus_go && !bus_rd && !region |=>
         st_reg.ctrl == ($past(st_reg.b2.din) & tss_pkg::CTRL_WMASK);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control register write lost");

   property p_split_write;
      bus_go && !bus_rd && region && split |=>
         st_reg.cml[$past(bus_idx)] == $past(st_reg.b2.din);
   endproperty
   a_split_write: assert property (p_split_write)
      else $error("split write missed low memory");

   // Acknowledge keeps standing while the access is still presented
   property p_ack_hold;
      st_reg.acc == tss_pkg::ACC_DONE && bus_act |=> access_ack_n_oe;
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("acknowledge dropped while access still held");

   property p_ack_seen;
      bus_go |=> access_ack_n_oe;
   endproperty
   a_ack_seen: assert property (p_ack_seen)
      else $error("access not acknowledged next cycle");

   c_frame: cover property (fall && !st_reg.fp_s2);
   c_msg: cover property (load && load_msg[0] && !load_oe[1]);
   c_read: cover property (bus_go && bus_rd && region);
   c_full: cover property (full);
endmodule : tdm_time_slot_switch
`default_nettype wire

// ===== dv/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
   input  wire logic       mclk,      // System clock
   input  wire logic       ack_n_out, // Acknowledge level
   input  wire logic       ack_n_oe,  // Acknowledge pull-down
   input  wire logic [7:0] dout,      // Read data
   input  wire logic       dout_oe,   // Read data drive
   output logic            cs_n,      // Chip select
   output logic            strobe,    // Data strobe
   output logic            rw,        // High read
   output logic            region,    // Top address line
   output logic      [4:0] addr,      // Channel address
   output logic      [7:0] din        // Write data
);
   // Open-drain acknowledge sits on a pull-up
   wire ack_n = ack_n_oe ? ack_n_out : 1'b1;

   // Idle bus at time zero
   initial begin
      cs_n = 1'b1;
      strobe = 1'b0;
      rw = 1'b1;
      region = 1'b0;
      addr = 5'h00;
      din = 8'h00;
   end

   // One access; every access waits for the acknowledge
   task automatic access(input logic r, input logic [5:0] a,
                         input logic [7:0] d, output logic [7:0] q,
                         output logic ok);
      int n;
      @(negedge mclk);
      rw = r;
      region = a[5];
      addr = a[4:0];
      din = d;
      cs_n = 1'b0;
      strobe = 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack_n !== 1'b0 && n < 40);
      q = dout_oe ? dout : 8'hxx;
      ok = (n < 40);
      @(negedge mclk);
      strobe = 1'b0;
      cs_n = 1'b1;
      din = ~d; // Released lines must not keep the last value
      n = 0;
      while (ack_n !== 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 40) ok = 1'b0;
   endtask : access
endmodule : cpu_bus_model
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [5:0] aw;
      logic [7:0] wd;
      logic [5:0] ar;
      logic [7:0] ex;
   } row_type;
   logic       mclk = 1'b0, rstn = 1'b0, bit_clock_n = 1'b1;
   logic       frame_pulse_n = 1'b0, output_drive_enable = 1'b1;
   logic [3:0] serial_in_lane = 4'h0;
   logic [3:0] so, soe, sctl;
   logic       cs_n, strobe, rw, region, data_oe, ack_out, ack_oe, ok;
   logic [4:0] addr_low;
   logic [7:0] din, dout, q, ib;
   logic       bprev = 1'b1;
   logic [8:0] cnt = 9'h1ff;
   int         n_fail = 0, checked = 0, frames = 0;
   logic [7:0] cap [4][32];
   logic       capoe [4][32], capctl [4][32];
   row_type    rows [3] = '{'{6'h00, 8'hff, 6'h1f, 8'hdb},
                            '{6'h15, 8'h24, 6'h00, 8'h00},
                            '{6'h1f, 8'h5a, 6'h0a, 8'h5a}};

   always #2 mclk = ~mclk;
   // Link clock, unrelated in phase to mclk
   always #62.5 bit_clock_n = ~bit_clock_n;

   tdm_time_slot_switch dut_u (.mclk(mclk), .rstn(rstn),
      .bit_clock_n(bit_clock_n), .frame_pulse_n(frame_pulse_n),
      .serial_in_lane(serial_in_lane),
      .output_drive_enable(output_drive_enable),
      .serial_out_lane(so), .serial_out_oe(soe),
      .channel_control_out(sctl), .chip_select_n(cs_n),
      .access_strobe(strobe), .read_write(rw),
      .region_select_line(region), .bus_addr_low(addr_low),
      .bus_data_in(din), .bus_data_out(dout), .bus_data_oe(data_oe),
      .access_ack_n_out(ack_out), .access_ack_n_oe(ack_oe));
   cpu_bus_model bus_u (.mclk(mclk), .ack_n_out(ack_out),
      .ack_n_oe(ack_oe), .dout(dout), .dout_oe(data_oe), .cs_n(cs_n),
      .strobe(strobe), .rw(rw), .region(region), .addr(addr_low),
      .din(din));

   // Input byte carries its own lane and channel
   function automatic logic [7:0] in_byte(input int l,
                                          input logic [4:0] c);
      return {1'b1, l[1:0], c};
   endfunction : in_byte

   // Stream side: even edges start a cell, odd edges sample mid-cell
   always @(negedge mclk) begin
      bprev <= bit_clock_n;
      // Frame pulse moves on rising edges, clear of the falling edge it marks
      if (!bprev && bit_clock_n) begin
         frame_pulse_n <= (cnt != 9'h1ff);
      end
      if (bprev && !bit_clock_n) begin
         cnt = cnt + 9'h001;
         if (cnt == 9'h000) frames++;
         for (int l = 0; l < 4; l++) begin
            ib = in_byte(l, cnt[8:4]);
            if (!cnt[0]) serial_in_lane[l] <= ib[3'h7 - cnt[3:1]];
            else cap[l][cnt[8:4]][3'h7 - cnt[3:1]] = so[l];
            if (cnt[3:0] == 4'h1) begin
               capoe[l][cnt[8:4]] = soe[l];
               capctl[l][cnt[8:4]] = sctl[l];
            end
         end
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus_u.access(1'b0, a, d, q, ok);
      chk({7'h00, ok}, 8'h01);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      bus_u.access(1'b1, a, 8'h00, q, ok);
      chk({7'h00, ok}, 8'h01);
      chk(q, e);
   endtask : rd

   task automatic wait_frames(input int n);
      int f0;
      f0 = frames;
      while (frames < f0 + n) @(negedge mclk);
   endtask : wait_frames

   task automatic report_and_stop;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   // Watchdog sized for about five and a half frames of traffic
   initial begin
      #360000;
      n_fail++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      repeat (3) @(negedge mclk);
      chk({soe, 2'h0, data_oe, ack_oe}, 8'h00);
      @(negedge mclk);
      rstn = 1'b1;
      rd(6'h00, tss_pkg::CTRL_RESET);
      // Control register rows: any low address reaches it
      foreach (rows[i]) begin
         wr(rows[i].aw, rows[i].wd);
         rd(rows[i].ar, rows[i].ex);
      end
      // Message channel on lane 1, switched channel on lane 2
      wr(6'h00, 8'h11);
      wr(6'h23, 8'ha5);
      wr(6'h00, 8'h19);
      wr(6'h23, 8'h07);
      wr(6'h00, 8'h12);
      wr(6'h27, 8'h65);
      rd(6'h27, 8'h65);
      wr(6'h00, 8'h1a);
      wr(6'h27, 8'h01);
      wr(6'h00, 8'h81);
      wr(6'h2a, 8'h3c);
      wr(6'h00, 8'h11);
      rd(6'h2a, 8'h3c);
      wait_frames(2);
      chk(cap[1][3], 8'ha5);
      chk({6'h00, capoe[1][3], capctl[1][3]}, 8'h03);
      chk(cap[2][7], 8'he5);
      chk({6'h00, capoe[2][7], capctl[2][7]}, 8'h02);
      chk({7'h00, capoe[1][4]}, 8'h00);
      wr(6'h00, 8'h08);
      rd(6'h25, 8'h85);
      wr(6'h00, 8'h0b);
      rd(6'h3f, 8'hff);
      wr(6'h00, 8'h81);
      rd(6'h25, 8'ha5);
      // Memory select 00 names no memory: read back as zero
      wr(6'h00, 8'h01);
      rd(6'h25, 8'h00);
      // Broadcast forces message mode and drive everywhere
      wr(6'h00, 8'h40);
      wait_frames(2);
      chk(cap[1][10], 8'h3c);
      chk({6'h00, capoe[0][0], capoe[3][31]}, 8'h03);
      @(negedge mclk);
      output_drive_enable = 1'b0;
      repeat (8) @(negedge mclk);
      chk({4'h0, soe}, 8'h00);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
